//--- asm_top.sv
// Notes on behaviour
// - Raise ignition wire fault 2 on L2/L3 wire fault report.
// - Raise ignition voltage alarm 1 or 2 on low capacitor charge.
// - Raise constellation alarm when present peers differ from configured peers.
// - Constellation alarm also when detected ring/line differs from setting.
// - Raise compatibility alarm on inconsistent peer firmware versions.
// - Raise address conflict alarm when two masters share an address.
// - Raise faulty light alarm when any channel sees light over ten seconds.
// - Raise overheat alarm while temperature monitor reports over limit.
// - Raise display address conflict on duplicate display unit addresses.
// - Raise display parameter alarm on missing or corrupt display parameter.
// - List holds 100 entries; overflow flagged when an alarm to store finds no free entry.
// - Overflow acknowledge refused while any other alarm is active.
// - Raise zone trip alarm when a peer master reports a trip.
// - Zone trip ack needs source trip gone and its local trip acknowledged.
// - Zone trip ack also allowed once the source master is gone.
// - Raise sensor short alarm on a shorted or damaged sensor.
// - No-free-entry condition when storing with every position occupied.
// - Acknowledge accepted only once the causing condition is inactive.
// - Relay on for any system error until all errors are acknowledged.
module asm_top #(
   parameter int NP = 8,
   parameter int NCH = 3,
   parameter int TICK_CYC = asm_pkg::TICK_CYC,
   parameter int LIGHT_MS = asm_pkg::LIGHT_MS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ign_wire2_fault,
   input wire logic ign_volt1_low,
   input wire logic ign_volt2_low,
   input wire logic topo_ring_seen,
   input wire logic peer_fw_mismatch,
   input wire logic peer_addr_dup,
   input wire logic over_temp,
   input wire logic disp_addr_dup,
   input wire logic disp_param_err,
   input wire logic [NP-1:0] peer_present,
   input wire logic [NP-1:0] peer_trip,
   input wire logic [NP-1:0] peer_trip_acked,
   input wire logic [NCH-1:0] sensor_light,
   input wire logic [NCH-1:0] sensor_short,
   output logic relay_q,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NA = asm_pkg::NUM_ALM;
   localparam int LL = asm_pkg::LIST_LEN;
   localparam int PW = 9 + 3 * NP + 2 * NCH;
   localparam int P_PRES = 9;
   localparam int P_TRIP = 9 + NP;
   localparam int P_TACK = 9 + 2 * NP;
   localparam int P_LIGHT = 9 + 3 * NP;
   localparam int P_SHORT = 9 + 3 * NP + NCH;

   // Pin sampling: three stages, change taken when stages 2 and 3 agree
   logic [PW-1:0] pin_raw;
   logic [PW-1:0] s1_q, s2_q, s3_q, flt_q;
   assign pin_raw = {sensor_short, sensor_light, peer_trip_acked, peer_trip, peer_present,
                     disp_param_err, disp_addr_dup, over_temp, peer_addr_dup,
                     peer_fw_mismatch, topo_ring_seen, ign_volt2_low, ign_volt1_low,
                     ign_wire2_fault};
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         flt_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
      end
   end

   logic [NP-1:0] pres, trip, tack;
   logic [NCH-1:0] light, shrt;
   assign pres = flt_q[P_PRES +: NP];
   assign trip = flt_q[P_TRIP +: NP];
   assign tack = flt_q[P_TACK +: NP];
   assign light = flt_q[P_LIGHT +: NCH];
   assign shrt = flt_q[P_SHORT +: NCH];

   // Millisecond enable from a divider
   logic [31:0] div_q;
   logic tick_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (div_q == 32'(TICK_CYC - 1));
         div_q <= (div_q == 32'(TICK_CYC - 1)) ? '0 : div_q + 32'h1;
      end
   end

   // Per-channel continuous light timers
   logic [NCH-1:0] light_long;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_light
         logic [31:0] ms_q;
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               ms_q <= '0;
            end else if (!light[g]) begin
               ms_q <= '0;
            end else if (tick_q && ms_q <= 32'(LIGHT_MS)) begin
               ms_q <= ms_q + 32'h1;
            end
         end
         assign light_long[g] = ms_q > 32'(LIGHT_MS);
      end
   endgenerate

   // Configuration register
   logic [31:0] cfg_q;
   logic [NP-1:0] cfg_peers;
   logic cfg_ring;
   assign cfg_peers = cfg_q[NP-1:0];
   assign cfg_ring = cfg_q[asm_pkg::CFG_RING_POS];

   // Alarm source conditions
   logic [NA-1:0] cond;
   assign cond[asm_pkg::A_WIRE2] = flt_q[0];
   assign cond[asm_pkg::A_VOLT1] = flt_q[1];
   assign cond[asm_pkg::A_VOLT2] = flt_q[2];
   assign cond[asm_pkg::A_CONST] = (pres != cfg_peers) || (flt_q[3] != cfg_ring);
   assign cond[asm_pkg::A_COMPAT] = flt_q[4];
   assign cond[asm_pkg::A_MADDR] = flt_q[5];
   assign cond[asm_pkg::A_LIGHT] = |light_long;
   assign cond[asm_pkg::A_HEAT] = flt_q[6];
   assign cond[asm_pkg::A_DADDR] = flt_q[7];
   assign cond[asm_pkg::A_DPAR] = flt_q[8];
   assign cond[asm_pkg::A_ZONE] = |(trip & pres);
   assign cond[asm_pkg::A_SHORT] = |shrt;

   // Alarm state
   logic [NA-1:0] cond_q, act_q, pend_q;
   logic [NP-1:0] zsrc_q;
   logic ovf_q;
   logic [LL-1:0] vld_q;
   logic [7:0] code_mem [LL];
   logic [6:0] cnt_q;
   logic [NA-1:0] rise;
   assign rise = cond & ~cond_q;

   // Lowest pending slot and first free entry
   logic st_any;
   logic [3:0] st_slot;
   logic fr_any;
   logic [6:0] fr_idx;
   always_comb begin
      st_any = 1'b0;
      st_slot = '0;
      fr_any = 1'b0;
      fr_idx = '0;
      for (int i = NA - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            st_any = 1'b1;
            st_slot = 4'(i);
         end
      end
      for (int i = LL - 1; i >= 0; i--) begin
         if (!vld_q[i]) begin
            fr_any = 1'b1;
            fr_idx = 7'(i);
         end
      end
   end

   // Acknowledge request decode
   logic wr_go, rd_go, ack_wr;
   logic [7:0] ack_code;
   logic ack_ovf, ack_hit;
   logic [3:0] ack_slot;
   logic zone_ok;
   assign ack_code = s_axi_wdata[7:0];
   assign ack_wr = wr_go && s_axi_awaddr == asm_pkg::OFS_ACK && s_axi_wstrb[0];
   assign ack_ovf = ack_code == asm_pkg::CODE_OVF;
   // source cleared and acked, or gone
   assign zone_ok = &(~zsrc_q | ~pres | (~trip & tack));
   always_comb begin
      ack_hit = 1'b0;
      ack_slot = '0;
      for (int i = 0; i < NA; i++) begin
         if (ack_code == asm_pkg::CODE_TAB[i]) begin
            ack_hit = 1'b1;
            ack_slot = 4'(i);
         end
      end
   end

   logic ack_ok, ovf_ok;
   assign ovf_ok = ack_wr && ack_ovf && ovf_q && act_q == '0;
   assign ack_ok = ack_wr && ack_hit && act_q[ack_slot] && !cond[ack_slot] &&
                   (ack_slot != 4'(asm_pkg::A_ZONE) || zone_ok);

   // Entry that holds the acknowledged code
   logic fm_any;
   logic [6:0] fm_idx;
   always_comb begin
      fm_any = 1'b0;
      fm_idx = '0;
      for (int i = LL - 1; i >= 0; i--) begin
         if (vld_q[i] && code_mem[i] == asm_pkg::CODE_TAB[ack_slot]) begin
            fm_any = 1'b1;
            fm_idx = 7'(i);
         end
      end
   end

   logic do_store, do_free, store_fail;
   assign do_free = ack_ok && fm_any;
   assign do_store = st_any && fr_any;
   assign store_fail = st_any && !fr_any;

   logic [NA-1:0] clr_vec, st_vec;
   assign clr_vec = ack_ok ? NA'(1) << ack_slot : '0;
   assign st_vec = st_any ? NA'(1) << st_slot : '0;

   // Alarm flags; raising wins over acknowledge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cond_q <= '0;
         act_q <= '0;
         pend_q <= '0;
         zsrc_q <= '0;
         ovf_q <= 1'b0;
      end else begin
         cond_q <= cond;
         act_q <= (act_q & ~clr_vec) | rise;
         pend_q <= (pend_q & ~st_vec & ~clr_vec) | rise;
         zsrc_q <= (clr_vec[asm_pkg::A_ZONE] ? '0 : zsrc_q) | (trip & pres);
         ovf_q <= store_fail | (ovf_q & !ovf_ok);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vld_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_free) vld_q[fm_idx] <= 1'b0;
         if (do_store) vld_q[fr_idx] <= 1'b1;
         cnt_q <= cnt_q + 7'(do_store) - 7'(do_free);
      end
   end
   always_ff @(posedge clock) begin
      if (do_store) code_mem[fr_idx] <= asm_pkg::CODE_TAB[st_slot];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) relay_q <= 1'b0;
      else relay_q <= (|act_q) || ovf_q;
   end

   // AXI4-Lite write channel
   logic ack_ok_q, ack_rej_q;
   logic [6:0] idx_q;
   logic wr_map;
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign wr_map = s_axi_awaddr == asm_pkg::OFS_CFG || s_axi_awaddr == asm_pkg::OFS_ACK ||
                   s_axi_awaddr == asm_pkg::OFS_IDX;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= asm_pkg::RESP_OKAY;
         cfg_q <= asm_pkg::CFG_RST;
         idx_q <= '0;
         ack_ok_q <= 1'b0;
         ack_rej_q <= 1'b0;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? asm_pkg::RESP_OKAY : asm_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go && s_axi_awaddr == asm_pkg::OFS_CFG && s_axi_wstrb[0])
            cfg_q[7:0] <= s_axi_wdata[7:0];
         if (wr_go && s_axi_awaddr == asm_pkg::OFS_CFG && s_axi_wstrb[1])
            cfg_q[15:8] <= s_axi_wdata[15:8];
         if (wr_go && s_axi_awaddr == asm_pkg::OFS_IDX && s_axi_wstrb[0])
            idx_q <= s_axi_wdata[6:0];
         if (ack_wr) begin
            ack_ok_q <= ack_ok || ovf_ok;
            ack_rej_q <= !(ack_ok || ovf_ok);
         end
      end
   end

   // Read data selection
   logic [31:0] rd_mux;
   logic rd_map;
   logic idx_in;
   assign idx_in = idx_q < 7'(LL);
   assign rd_go = s_axi_arvalid && s_axi_arready;
   always_comb begin
      rd_map = 1'b1;
      rd_mux = '0;
      if (s_axi_araddr == asm_pkg::OFS_CFG) begin
         rd_mux = cfg_q & 32'h0000_01ff;
      end else if (s_axi_araddr == asm_pkg::OFS_STAT) begin
         rd_mux[NA-1:0] = act_q;
         rd_mux[asm_pkg::STAT_OVF_POS] = ovf_q;
         rd_mux[asm_pkg::STAT_RELAY_POS] = relay_q;
         rd_mux[asm_pkg::STAT_ACKOK_POS] = ack_ok_q;
         rd_mux[asm_pkg::STAT_ACKREJ_POS] = ack_rej_q;
      end else if (s_axi_araddr == asm_pkg::OFS_CNT) begin
         rd_mux[6:0] = cnt_q;
      end else if (s_axi_araddr == asm_pkg::OFS_IDX) begin
         rd_mux[6:0] = idx_q;
      end else if (s_axi_araddr == asm_pkg::OFS_ENTRY && idx_in) begin
         rd_mux[7:0] = code_mem[idx_q];
         rd_mux[asm_pkg::ENTRY_VLD_POS] = vld_q[idx_q];
      end else if (s_axi_araddr == asm_pkg::OFS_ENTRY) begin
         rd_mux = '0;
      end else begin
         rd_map = 1'b0;
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= asm_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_map ? asm_pkg::RESP_OKAY : asm_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   relay_follow_a: assert property ((|act_q || ovf_q) |=> relay_q)
      else $error("relay off with alarm pending");
   relay_idle_a: assert property (!(|act_q) && !ovf_q |=> !relay_q)
      else $error("relay on with no alarm");
   ack_busy_a: assert property (ack_wr && ack_hit && cond[ack_slot] |=> ack_rej_q && !ack_ok_q)
      else $error("ack taken while source active");
   ovf_hold_a: assert property (ack_wr && ack_ovf && ovf_q && |act_q |=> ovf_q)
      else $error("overflow ack while alarms active");
   ovf_set_a: assert property (st_any && vld_q == '1 |=> ovf_q)
      else $error("overflow not flagged on full list");
   list_bound_a: assert property (cnt_q <= 7'(LL))
      else $error("alarm list count above bound");
   zone_hold_a: assert property (ack_wr && ack_code == asm_pkg::CODE_TAB[asm_pkg::A_ZONE] && !zone_ok
      |=> act_q[asm_pkg::A_ZONE] || !$past(act_q[asm_pkg::A_ZONE]))
      else $error("zone trip ack before source cleared");
   raise_a: assert property (rise[asm_pkg::A_ZONE] |=> act_q[asm_pkg::A_ZONE] ##1 relay_q)
      else $error("zone trip not raised");
   entry_free_a: assert property (do_free && !do_store |=> cnt_q == $past(cnt_q) - 7'h1)
      else $error("acked entry not freed");

   ack_cov_c: cover property (ack_ok);
   ovf_cov_c: cover property (ovf_ok);
   light_cov_c: cover property (rise[asm_pkg::A_LIGHT]);
endmodule // asm_top

//--- asm_pkg.sv
package asm_pkg;
   // Clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int LIGHT_S = 10;
   localparam int LIGHT_MS = LIGHT_S * 1000;
   // Alarm list
   localparam int LIST_LEN = 100;
   localparam int NUM_ALM = 12;
   // Alarm slots
   localparam int A_WIRE2 = 0;
   localparam int A_VOLT1 = 1;
   localparam int A_VOLT2 = 2;
   localparam int A_CONST = 3;
   localparam int A_COMPAT = 4;
   localparam int A_MADDR = 5;
   localparam int A_LIGHT = 6;
   localparam int A_HEAT = 7;
   localparam int A_DADDR = 8;
   localparam int A_DPAR = 9;
   localparam int A_ZONE = 10;
   localparam int A_SHORT = 11;
   // Alarm codes, index by slot
   localparam logic [7:0] CODE_TAB [NUM_ALM] = '{
      8'h22, 8'h23, 8'h24, 8'h26, 8'h27, 8'h28,
      8'h2f, 8'h30, 8'h31, 8'h34, 8'h36, 8'h37};
   localparam logic [7:0] CODE_OVF = 8'h35;
   // Register byte addresses
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_ACK = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CNT = 8'h0c;
   localparam logic [7:0] OFS_IDX = 8'h10;
   localparam logic [7:0] OFS_ENTRY = 8'h14;
   // Field positions and reset values
   localparam int CFG_RING_POS = 8;
   localparam int STAT_OVF_POS = 12;
   localparam int STAT_RELAY_POS = 13;
   localparam int STAT_ACKOK_POS = 16;
   localparam int STAT_ACKREJ_POS = 17;
   localparam int ENTRY_VLD_POS = 8;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- asm_far_model.sv
module asm_far_model (
   output logic [10:0] flag_q,
   output logic ring_q,
   output logic [7:0] present_q,
   output logic [7:0] trip_q,
   output logic [7:0] acked_q,
   output logic [2:0] light_q
);
   timeunit 1ns;
   timeprecision 1ps;

   // Healthy units and quiet peer link at power-up
   initial begin
      flag_q = 11'h000;
      ring_q = 1'b0;
      present_q = 8'h00;
      trip_q = 8'h00;
      acked_q = 8'h00;
      light_q = 3'h0;
   end

   // Unit fault reports, held as levels; call just after a clock edge
   task automatic set_flag(input int i, input logic v);
      flag_q[i] <= v;
   endtask

   // Detected cabling, 1 for ring
   task automatic set_ring(input logic v);
      ring_q <= v;
   endtask

   // A peer that has left the link reports neither trip nor acknowledge
   task automatic set_peers(input logic [7:0] p, input logic [7:0] t, input logic [7:0] a);
      present_q <= p;
      trip_q <= t & p;
      acked_q <= a & p;
   endtask

   // Light seen per sensor channel
   task automatic set_light(input logic [2:0] v);
      light_q <= v;
   endtask
endmodule // asm_far_model

//--- asm_top_tb_top.sv
module asm_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, ring, relay;
   logic [10:0] flag;
   logic [7:0] pres, trip, tack, awaddr, araddr;
   logic [2:0] light;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, st;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   int fail_count, num_checks, i;
   int slot_map [11] = '{asm_pkg::A_WIRE2, asm_pkg::A_VOLT1, asm_pkg::A_VOLT2, asm_pkg::A_COMPAT,
      asm_pkg::A_MADDR, asm_pkg::A_HEAT, asm_pkg::A_DADDR, asm_pkg::A_DPAR, asm_pkg::A_SHORT,
      asm_pkg::A_SHORT, asm_pkg::A_SHORT};

   asm_far_model asm_far_model_inst (.flag_q(flag), .ring_q(ring), .present_q(pres),
      .trip_q(trip), .acked_q(tack), .light_q(light));

   // Short tick and light limit keep the run brief
   asm_top #(.TICK_CYC(4), .LIGHT_MS(5)) asm_top_inst (.clock(clock), .rst(rst),
      .ign_wire2_fault(flag[0]), .ign_volt1_low(flag[1]), .ign_volt2_low(flag[2]),
      .topo_ring_seen(ring), .peer_fw_mismatch(flag[3]), .peer_addr_dup(flag[4]),
      .over_temp(flag[5]), .disp_addr_dup(flag[6]), .disp_param_err(flag[7]),
      .peer_present(pres), .peer_trip(trip), .peer_trip_acked(tack), .sensor_light(light),
      .sensor_short(flag[10:8]), .relay_q(relay), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   // 50 MHz clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            rsp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   // Bus read into st and rsp
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arready) begin
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            st = rdata;
            rsp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // Active alarm, overflow and relay bits of the status word
   task automatic sc(input logic [13:0] exp);
      rd(asm_pkg::OFS_STAT);
      chk("status", {18'h0, st[13:0]}, {18'h0, exp});
   endtask

   // Acknowledge a code; e is {rejected, accepted}
   task automatic ack(input logic [7:0] code, input logic [1:0] e);
      wr(asm_pkg::OFS_ACK, {24'h0, code});
      chk("ack bresp", {30'h0, rsp}, {30'h0, asm_pkg::RESP_OKAY});
      rd(asm_pkg::OFS_STAT);
      chk("ack result", {30'h0, st[17:16]}, {30'h0, e});
   endtask

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b0;
      rready = 1'b0;
      wt(10);
      rst <= 1'b0;
      wt(1);
      // Reset state and bus refusals
      rd(asm_pkg::OFS_CFG);
      chk("cfg reset", st, asm_pkg::CFG_RST);
      sc(14'h0000);
      chk("relay idle", {31'h0, relay}, 32'h0);
      rd(8'h18);
      chk("unmapped rresp", {30'h0, rsp}, {30'h0, asm_pkg::RESP_SLVERR});
      chk("unmapped rdata", st, 32'h0);
      wr(8'h18, 32'h1);
      chk("unmapped bresp", {30'h0, rsp}, {30'h0, asm_pkg::RESP_SLVERR});
      wr(asm_pkg::OFS_STAT, 32'h1);
      chk("ro bresp", {30'h0, rsp}, {30'h0, asm_pkg::RESP_SLVERR});
      // Index write without its low byte strobe leaves the index alone
      wstrb <= 4'he;
      wr(asm_pkg::OFS_IDX, 32'h5);
      wstrb <= 4'hf;
      rd(asm_pkg::OFS_IDX);
      chk("idx strobe", st, 32'h0);
      wr(asm_pkg::OFS_IDX, 32'h64);
      rd(asm_pkg::OFS_ENTRY);
      chk("entry past end", st, 32'h0);
      wr(asm_pkg::OFS_IDX, 32'h0);
      // Each level fault: raise, store, refuse ack while active, then accept
      for (i = 0; i < 11; i++) begin
         asm_far_model_inst.set_flag(i, 1'b1);
         wt(8);
         sc(14'h2000 | (14'h1 << slot_map[i]));
         rd(asm_pkg::OFS_ENTRY);
         chk("entry", st, {23'h0, 1'b1, asm_pkg::CODE_TAB[slot_map[i]]});
         rd(asm_pkg::OFS_CNT);
         chk("count", st, 32'h1);
         ack(asm_pkg::CODE_TAB[slot_map[i]], 2'h2);
         asm_far_model_inst.set_flag(i, 1'b0);
         wt(8);
         ack(asm_pkg::CODE_TAB[slot_map[i]], 2'h1);
         sc(14'h0000);
         rd(asm_pkg::OFS_CNT);
         chk("count freed", st, 32'h0);
         chk("relay off", {31'h0, relay}, 32'h0);
      end
      // Cabling differs from setting, then setting follows
      asm_far_model_inst.set_ring(1'b1);
      wt(8);
      sc(14'h2008);
      wr(asm_pkg::OFS_CFG, 32'h100);
      wt(8);
      ack(8'h26, 2'h1);
      asm_far_model_inst.set_peers(8'h04, 8'h00, 8'h00);
      wt(8);
      sc(14'h2008);
      asm_far_model_inst.set_peers(8'h00, 8'h00, 8'h00);
      wt(8);
      ack(8'h26, 2'h1);
      // Peer trip: ack needs trip gone and remote acknowledge
      // New setting leads the synchronised peer pins, so a short mismatch is flagged
      wr(asm_pkg::OFS_CFG, 32'h102);
      asm_far_model_inst.set_peers(8'h02, 8'h00, 8'h00);
      wt(8);
      sc(14'h2008);
      ack(8'h26, 2'h1);
      asm_far_model_inst.set_peers(8'h02, 8'h02, 8'h00);
      wt(8);
      sc(14'h2400);
      asm_far_model_inst.set_peers(8'h02, 8'h00, 8'h00);
      wt(8);
      ack(8'h36, 2'h2);
      asm_far_model_inst.set_peers(8'h02, 8'h00, 8'h02);
      wt(8);
      ack(8'h36, 2'h1);
      sc(14'h0000);
      // Source master leaves the link
      asm_far_model_inst.set_peers(8'h02, 8'h02, 8'h00);
      wt(8);
      asm_far_model_inst.set_peers(8'h00, 8'h00, 8'h00);
      wt(8);
      sc(14'h2408);
      ack(8'h36, 2'h1);
      wr(asm_pkg::OFS_CFG, 32'h100);
      wt(8);
      ack(8'h26, 2'h1);
      sc(14'h0000);
      // Short light burst ignored, long one flagged
      asm_far_model_inst.set_light(3'h2);
      wt(12);
      asm_far_model_inst.set_light(3'h0);
      wt(8);
      sc(14'h0000);
      asm_far_model_inst.set_light(3'h2);
      wt(40);
      sc(14'h2040);
      asm_far_model_inst.set_light(3'h0);
      wt(8);
      ack(8'h2f, 2'h1);
      // Fill the list with repeated overheat reports
      for (i = 0; i < 101; i++) begin
         asm_far_model_inst.set_flag(5, 1'b1);
         wt(6);
         asm_far_model_inst.set_flag(5, 1'b0);
         wt(6);
         if (i == 99) begin
            rd(asm_pkg::OFS_CNT);
            chk("count full", st, 32'h64);
            sc(14'h2080);
         end
      end
      sc(14'h3080);
      ack(asm_pkg::CODE_OVF, 2'h2);
      ack(8'h30, 2'h1);
      sc(14'h3000);
      ack(asm_pkg::CODE_OVF, 2'h1);
      sc(14'h0000);
      chk("relay final", {31'h0, relay}, 32'h0);
      conclude();
   end
endmodule // asm_top_tb_top
